// File: shared/ssm_pkg.sv
// constants and types for the motion sensor serial port block
// Operation
// - step down through three rest levels at 237 ms, 8.4 s, 504 s without motion
// - rest levels sample motion every 16.5 ms, 82 ms, 410 ms
// - motion output held low while motion flag is set
// - flag clears after reading y and x, or writing motion register
// - illumination pulses only when a capture needs it
// - master starts every exchange; device never starts one
// - deselected: ignore clock and data, data output high impedance
// - port enabled only after chip select falls low
// - chip select rising mid transaction discards it and resets port
// - after a burst port refused until chip select rises
// - write is address byte with msb 1, then data byte
// - input data sampled on each rising serial clock edge
// - read is address with msb 0, device shifts data out on falling edges
// - reading stream_readout bursts motion, y, x, quality back to back
package ssm_pkg;
    localparam int CLK_MHZ = 250;
    // times in their own units, as printed
    localparam int REST1_DOWN_US = 237000;
    localparam int REST2_DOWN_MS = 8400;
    localparam int REST3_DOWN_S = 504;
    localparam int REST1_RESP_US = 16500;
    localparam int REST2_RESP_MS = 82;
    localparam int REST3_RESP_MS = 410;
    // derived cycle counts (64-bit to hold the long ones)
    localparam longint REST1_DOWN_CYC = longint'(REST1_DOWN_US) * CLK_MHZ;
    localparam longint REST2_DOWN_CYC = longint'(REST2_DOWN_MS) * 1000 * CLK_MHZ;
    localparam longint REST3_DOWN_CYC = longint'(REST3_DOWN_S) * 1000000 * CLK_MHZ;
    localparam longint REST1_RESP_CYC = longint'(REST1_RESP_US) * CLK_MHZ;
    localparam longint REST2_RESP_CYC = longint'(REST2_RESP_MS) * 1000 * CLK_MHZ;
    localparam longint REST3_RESP_CYC = longint'(REST3_RESP_MS) * 1000 * CLK_MHZ;
    // register addresses
    localparam logic [6:0] ADDR_MOTION = 7'h02;
    localparam logic [6:0] ADDR_Y_DISP = 7'h03;
    localparam logic [6:0] ADDR_X_DISP = 7'h04;
    localparam logic [6:0] ADDR_QUALITY = 7'h05;
    localparam logic [6:0] ADDR_STREAM = 7'h42;
    localparam int MOTION_FLAG_BIT = 7;
    localparam int WRITE_FLAG_BIT = 7;
    localparam logic [1:0] BURST_LAST = 2'h3;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam int LED_PULSE_CYC = 16;
    localparam logic [7:0] REG_RESET = 8'h00;

    typedef enum logic [1:0] {
        SSM_RUN = 2'b00,
        SSM_REST1 = 2'b01,
        SSM_REST2 = 2'b10,
        SSM_REST3 = 2'b11
    } ssm_pwr_t;

    typedef enum logic [1:0] {
        SSM_ADDR = 2'b00,
        SSM_WDATA = 2'b01,
        SSM_RDATA = 2'b10,
        SSM_DONE = 2'b11
    } ssm_port_t;
endpackage

// File: shared/ssm_sync_if.sv
// carrier between the top and its pin synchroniser
`timescale 1ns/1ps
`default_nettype none
interface ssm_sync_if;
    logic sclk_s;
    logic mosi_s;
    logic cs_n_s;
    modport sync (output sclk_s, output mosi_s, output cs_n_s);
    modport user (input sclk_s, input mosi_s, input cs_n_s);
endinterface
`default_nettype wire

// File: hw/ssm_pin_sync.sv
// two-flop synchronisers for the serial pins
`timescale 1ns/1ps
`default_nettype none
module ssm_pin_sync (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // raw pins
    input wire logic sclk,
    input wire logic mosi,
    input wire logic cs_n,
    // synchronised side
    ssm_sync_if.sync sy
);
    logic [2:0] meta_q;
    logic [2:0] sync_q;

    // first stage read only by second; reset to deselected, clock parked high
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            meta_q <= 3'h5;
            sync_q <= 3'h5;
        end else begin
            meta_q <= {cs_n, mosi, sclk};
            sync_q <= meta_q;
        end
    end

    assign sy.sclk_s = sync_q[0];
    assign sy.mosi_s = sync_q[1];
    assign sy.cs_n_s = sync_q[2];
endmodule // ssm_pin_sync
`default_nettype wire

// File: hw/ssm_motion_port.sv
// serial slave port, motion flag and power level sequencing
`timescale 1ns/1ps
`default_nettype none
module ssm_motion_port
    import ssm_pkg::*;
#(
    parameter longint REST1_DOWN = REST1_DOWN_CYC,
    parameter longint REST2_DOWN = REST2_DOWN_CYC,
    parameter longint REST3_DOWN = REST3_DOWN_CYC,
    parameter longint REST1_RESP = REST1_RESP_CYC,
    parameter longint REST2_RESP = REST2_RESP_CYC,
    parameter longint REST3_RESP = REST3_RESP_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // serial pins
    input wire logic sclk,
    input wire logic mosi,
    input wire logic cs_n,
    output logic miso_o,
    output logic miso_oe,
    // motion engine side
    input wire logic motion_seen,
    input wire logic [7:0] y_delta,
    input wire logic [7:0] x_delta,
    input wire logic [7:0] quality,
    output logic capture_req,
    // pins and state out
    output logic motion_n,
    output logic led_on,
    output logic [1:0] power_level
);
    ssm_sync_if sy ();

    ssm_pin_sync u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sclk(sclk),
        .mosi(mosi),
        .cs_n(cs_n),
        .sy(sy)
    );

    // port state
    ssm_port_t st_q, st_d;
    logic sclk_d1_q;
    logic [2:0] bit_q;
    logic [7:0] shift_q;
    logic [7:0] addr_q;
    logic [7:0] out_q;
    logic [1:0] burst_q;
    logic burst_q_act;
    logic miso_q, miso_oe_q;
    // motion and power state
    logic motion_q;
    logic motion_n_q; // pin copy, so the pin leaves a flop directly
    logic y_read_q, x_read_q;
    logic [7:0] y_q, x_q, qual_q;
    ssm_pwr_t pwr_q, pwr_d;
    logic [63:0] idle_q;
    logic [63:0] samp_q;
    logic capture_q;
    logic [4:0] led_cnt_q;
    logic led_q;

    function automatic logic [7:0] reg_mux(input logic [6:0] a, input logic m,
                                           input logic [7:0] y, input logic [7:0] x,
                                           input logic [7:0] q);
        logic [7:0] r;
        r = REG_RESET;
        case (a)
            ADDR_MOTION: r[MOTION_FLAG_BIT] = m;
            ADDR_Y_DISP: r = y;
            ADDR_X_DISP: r = x;
            ADDR_QUALITY: r = q;
            default: r = REG_RESET;
        endcase
        return r;
    endfunction

    // edge detection on the synchronised clock; gated by select
    wire selected = !sy.cs_n_s;
    wire sclk_rise = selected && sy.sclk_s && !sclk_d1_q;
    wire sclk_fall = selected && !sy.sclk_s && sclk_d1_q;
    wire byte_done = sclk_rise && (bit_q == BIT_LAST);
    wire [7:0] byte_in = {shift_q[6:0], sy.mosi_s};
    wire is_write = byte_in[WRITE_FLAG_BIT];
    wire is_stream = byte_in[6:0] == ADDR_STREAM;
    wire wr_motion = (st_q == SSM_WDATA) && byte_done && (addr_q[6:0] == ADDR_MOTION);
    wire rd_done = (st_q == SSM_RDATA) && byte_done;
    wire rd_y = rd_done && !burst_q_act && addr_q[6:0] == ADDR_Y_DISP;
    wire rd_x = rd_done && !burst_q_act && addr_q[6:0] == ADDR_X_DISP;
    // in a burst byte 1 is y and byte 2 is x
    wire brd_y = rd_done && burst_q_act && burst_q == 2'h1;
    wire brd_x = rd_done && burst_q_act && burst_q == 2'h2;
    wire y_seen = y_read_q || rd_y || brd_y;
    wire x_seen = x_read_q || rd_x || brd_x;
    wire flag_clear = wr_motion || (y_seen && x_seen);
    // next burst byte, loaded as the current one ends
    wire [7:0] burst_byte = (burst_q == 2'h0) ? y_q :
                            (burst_q == 2'h1) ? x_q : qual_q;

    // next port state; the device only answers, never opens an exchange
    always_comb begin
        st_d = st_q;
        case (st_q)
            SSM_ADDR: if (byte_done) st_d = is_write ? SSM_WDATA : SSM_RDATA;
            SSM_WDATA: if (byte_done) st_d = SSM_ADDR;
            SSM_RDATA: begin
                if (byte_done && !burst_q_act) st_d = SSM_ADDR;
                else if (byte_done && burst_q == BURST_LAST) st_d = SSM_DONE;
            end
            SSM_DONE: st_d = SSM_DONE;
            default: st_d = SSM_ADDR;
        endcase
    end

    // serial shift and framing; select high resets the port
    always_ff @(posedge ref_clk) begin
        if (!rst_n || sy.cs_n_s) begin
            st_q <= SSM_ADDR;
            bit_q <= 3'h0;
            shift_q <= REG_RESET;
            addr_q <= REG_RESET;
            out_q <= REG_RESET;
            burst_q <= 2'h0;
            burst_q_act <= 1'b0;
        end else begin
            st_q <= st_d;
            if (sclk_rise && st_q != SSM_DONE) begin
                bit_q <= bit_q + 3'h1;
                shift_q <= byte_in;
            end
            if (byte_done && st_q == SSM_ADDR) begin
                addr_q <= byte_in;
                burst_q_act <= !is_write && is_stream;
                // data latched after the last address bit
                out_q <= (!is_write && is_stream) ? {motion_q, 7'h00}
                         : reg_mux(byte_in[6:0], motion_q, y_q, x_q, qual_q);
            end else if (rd_done && burst_q_act && burst_q != BURST_LAST) begin
                burst_q <= burst_q + 2'h1;
                out_q <= burst_byte;
            end else if (sclk_fall && st_q == SSM_RDATA) begin
                out_q <= {out_q[6:0], 1'b0};
            end
        end
    end

    // output pin: drive only while selected in a read data phase
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sclk_d1_q <= 1'b1; // idle-high clock, no false edge after reset
            miso_q <= 1'b0;
            miso_oe_q <= 1'b0;
        end else begin
            sclk_d1_q <= sy.sclk_s;
            miso_oe_q <= selected && st_q == SSM_RDATA;
            if (sclk_fall && st_q == SSM_RDATA) miso_q <= out_q[7];
        end
    end

    // motion flag and snapshot registers; new motion wins over a clear
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            motion_q <= 1'b0;
            motion_n_q <= 1'b1;
            y_read_q <= 1'b0;
            x_read_q <= 1'b0;
            y_q <= REG_RESET;
            x_q <= REG_RESET;
            qual_q <= REG_RESET;
        end else if (motion_seen) begin
            motion_q <= 1'b1;
            motion_n_q <= 1'b0;
            y_read_q <= 1'b0;
            x_read_q <= 1'b0;
            y_q <= y_delta;
            x_q <= x_delta;
            qual_q <= quality;
        end else if (flag_clear) begin
            motion_q <= 1'b0;
            motion_n_q <= 1'b1;
            y_read_q <= 1'b0;
            x_read_q <= 1'b0;
        end else begin
            y_read_q <= y_seen;
            x_read_q <= x_seen;
        end
    end

    // downshift as idle time grows
    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            SSM_RUN: if (idle_q >= REST1_DOWN) pwr_d = SSM_REST1;
            SSM_REST1: if (idle_q >= REST2_DOWN) pwr_d = SSM_REST2;
            SSM_REST2: if (idle_q >= REST3_DOWN) pwr_d = SSM_REST3;
            SSM_REST3: pwr_d = SSM_REST3;
            default: pwr_d = SSM_RUN;
        endcase
        if (motion_seen) pwr_d = SSM_RUN;
    end

    // sample period per level; run mode captures every cycle slot
    wire [63:0] period = (pwr_q == SSM_REST1) ? 64'(REST1_RESP) :
                         (pwr_q == SSM_REST2) ? 64'(REST2_RESP) :
                         (pwr_q == SSM_REST3) ? 64'(REST3_RESP) : 64'h1;
    wire samp_due = samp_q + 64'h1 >= period;

    // idle timer counts from the last reported motion or the last level change
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pwr_q <= SSM_RUN;
            idle_q <= 64'h0;
            samp_q <= 64'h0;
            capture_q <= 1'b0;
        end else begin
            pwr_q <= pwr_d;
            idle_q <= (motion_seen || pwr_d != pwr_q) ? 64'h0 : idle_q + 64'h1;
            samp_q <= (samp_due || pwr_d != pwr_q) ? 64'h0 : samp_q + 64'h1;
            capture_q <= samp_due;
        end
    end

    // led flashes a 16-cycle pulse on a capture that finds it dark, captures during a pulse start none, instead of staying lit
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            led_cnt_q <= 5'h00;
            led_q <= 1'b0;
        end else if (capture_q && led_cnt_q == 5'h00) begin
            led_cnt_q <= 5'(LED_PULSE_CYC);
            led_q <= 1'b1;
        end else if (led_cnt_q != 5'h00) begin
            led_cnt_q <= led_cnt_q - 5'h01;
            led_q <= led_cnt_q != 5'h01;
        end
    end

    assign miso_o = miso_q;
    assign miso_oe = miso_oe_q;
    assign motion_n = motion_n_q;
    assign capture_req = capture_q;
    assign led_on = led_q;
    assign power_level = pwr_q;

    // checks
    // motion flag and pin
    chk_motion_pin_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
        motion_seen |=> !motion_n)
        else $error("motion pin not low after motion");
    chk_motion_stays_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!motion_q && !motion_seen) |=> motion_n)
        else $error("motion pin low without flag");
    chk_flag_write_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (wr_motion && !motion_seen) |=> motion_n)
        else $error("motion write did not clear");
    chk_flag_read_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (flag_clear && !motion_seen) |=> motion_n)
        else $error("flag clear did not raise pin");
    // serial port framing and routing
    chk_deselect_hiz: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sy.cs_n_s |=> !miso_oe)
        else $error("output driven while deselected");
    chk_idle_no_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_q != SSM_RDATA) |=> !miso_oe)
        else $error("output driven outside read data");
    chk_abort_port_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sy.cs_n_s |=> (st_q == SSM_ADDR && bit_q == 3'h0))
        else $error("port not reset");
    chk_burst_locked: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_q == SSM_DONE && !sy.cs_n_s) |=> st_q == SSM_DONE)
        else $error("burst lock left");
    chk_burst_no_count: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_q == SSM_DONE && !sy.cs_n_s) |=> $stable(bit_q))
        else $error("bits counted while locked");
    chk_write_route: assert property (@(posedge ref_clk) disable iff (!rst_n || sy.cs_n_s)
        (st_q == SSM_ADDR && byte_done && is_write) |=> st_q == SSM_WDATA)
        else $error("write address misrouted");
    chk_read_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_q == SSM_ADDR && byte_done && !is_write) |=> st_q == SSM_RDATA)
        else $error("read address misrouted");
    chk_shift_on_rise: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (sclk_rise && st_q != SSM_DONE) |=> shift_q[0] == $past(sy.mosi_s))
        else $error("input bit not taken on rise");
    chk_burst_next_y: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (rd_done && burst_q_act && burst_q == 2'h0) |=> out_q == $past(y_q))
        else $error("burst second byte not y");
    // power levels and illumination
    chk_run_on_motion: assert property (@(posedge ref_clk) disable iff (!rst_n)
        motion_seen |=> (pwr_q == SSM_RUN && idle_q == 64'h0))
        else $error("no wake");
    chk_downshift_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (pwr_q == SSM_RUN && idle_q < REST1_DOWN && !motion_seen) |=> pwr_q == SSM_RUN)
        else $error("downshift too early");
    chk_rest_sample_gap: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (capture_q && period != 64'h1) |=> !capture_q)
        else $error("rest level captured twice in a row");
    chk_capture_led: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (capture_q && led_cnt_q == 5'h00) |=> led_q)
        else $error("capture without led pulse");
    chk_led_pulse_end: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(led_q) |-> ##[1:20] !led_q)
        else $error("led left lit");
endmodule // ssm_motion_port
`default_nettype wire

// File: tb/ssm_host_model.sv
// host master model: frames, clocks and samples the serial port
`timescale 1ns/1ps
`default_nettype none
module ssm_host_model #(
    parameter int HALF_NS = 24,
    parameter int GAP_HALVES = 4
) (
    // serial pins towards the port
    output logic sclk,
    output logic mosi,
    output logic cs_n,
    // data back, Z while the port lets go
    input wire logic miso
);
    // idle: deselected, clock parked high, nothing sent unasked
    initial begin
        sclk = 1'b1;
        mosi = 1'b0;
        cs_n = 1'b1;
    end
    // select, odd offset keeps link edges off the core edges only when the frame opens on an even ns
    task automatic frame_open();
        #1;
        cs_n = 1'b0;
        #(2*HALF_NS);
    endtask
    // deselect, data inverted so a stale bit never lingers
    task automatic frame_close();
        #(HALF_NS);
        cs_n = 1'b1;
        mosi = ~mosi;
        #(4*HALF_NS);
    endtask
    // msb first; drive on falling, take the answer on rising
    task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - nbits; i--) begin
            sclk = 1'b0;
            mosi = tx[i];
            #(HALF_NS);
            sclk = 1'b1;
            rx[i] = miso;
            #(HALF_NS);
        end
    endtask
    // give the port time to fetch read data
    task automatic addr_gap();
        #(GAP_HALVES*HALF_NS);
    endtask
endmodule // ssm_host_model
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the motion sensor serial port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ssm_pkg::*;
    logic ref_clk, rst_n, sclk, mosi, cs_n, motion_seen;
    logic [7:0] y_delta, x_delta, quality, d;
    logic miso_o, miso_oe, capture_req, motion_n, led_on;
    logic [1:0] power_level;
    wire miso;
    int mismatches, comparisons;
    // resolved data line: floats when the port lets go
    assign miso = miso_oe ? miso_o : 1'bz;
    // short level thresholds keep the run brief; rest3 keeps its full sample period
    ssm_motion_port #(.REST1_DOWN(100), .REST2_DOWN(200), .REST3_DOWN(300),
        .REST1_RESP(10), .REST2_RESP(20)) u_ssm_motion_port (
        .ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk), .mosi(mosi), .cs_n(cs_n),
        .miso_o(miso_o), .miso_oe(miso_oe), .motion_seen(motion_seen),
        .y_delta(y_delta), .x_delta(x_delta), .quality(quality),
        .capture_req(capture_req), .motion_n(motion_n), .led_on(led_on),
        .power_level(power_level));
    ssm_host_model u_host (.sclk(sclk), .mosi(mosi), .cs_n(cs_n), .miso(miso));
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // one-cycle pulse from the motion engine with fresh data
    task automatic pulse(input logic [7:0] y, input logic [7:0] x, input logic [7:0] q);
        @(negedge ref_clk);
        {y_delta, x_delta, quality} = {y, x, q};
        motion_seen = 1'b1;
        @(negedge ref_clk);
        motion_seen = 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] r);
        logic [7:0] junk;
        u_host.xfer({1'b0, a}, 8, junk);
        u_host.addr_gap();
        u_host.xfer(8'h00, 8, r);
    endtask
    task automatic sel_rd(input logic [6:0] a, input logic [7:0] exp, input string w);
        u_host.frame_open();
        rd(a, d);
        check(d, exp, w);
        u_host.frame_close();
    endtask
    // count capture pulses and led cycles far from any capture
    task automatic watch(input int n, output int caps, output int stray);
        int since;
        caps = 0;
        stray = 0;
        since = 0;
        repeat (n) begin
            @(negedge ref_clk);
            since = (capture_req === 1'b1) ? 0 : since + 1;
            caps += (capture_req === 1'b1);
            stray += (led_on === 1'b1 && since > 17);
        end
    endtask
    task automatic wait_level(input logic [1:0] lv, input int lim);
        int k;
        k = 0;
        while (power_level !== lv && k < lim) begin
            @(negedge ref_clk);
            k++;
        end
        check({6'h00, power_level}, {6'h00, lv}, "power level");
    endtask
    // looked at while reset still holds: run mode captures at once after release
    task automatic t_reset();
        check({4'h0, motion_n, miso_oe, led_on, capture_req}, 8'h08, "reset outs");
        check({6'h00, power_level}, 8'h00, "reset level");
    endtask
    // reading y alone keeps the flag; x then clears it
    task automatic t_read_pair();
        pulse(8'h5A, 8'hC3, 8'h3C);
        check({7'h00, motion_n}, 8'h00, "motion low");
        sel_rd(ADDR_Y_DISP, 8'h5A, "y read");
        check({7'h00, motion_n}, 8'h00, "flag after y only");
        sel_rd(ADDR_X_DISP, 8'hC3, "x read");
        check({6'h00, motion_n, miso_oe}, 8'h02, "cleared, released");
    endtask
    task automatic t_write_clear();
        pulse(8'h01, 8'h02, 8'h03);
        u_host.frame_open();
        u_host.xfer({1'b1, ADDR_MOTION}, 8, d);
        u_host.xfer(8'h00, 8, d);
        u_host.frame_close();
        check({7'h00, motion_n}, 8'h01, "write clears flag");
    endtask
    // select dropped mid address: next read must start clean
    task automatic t_abort();
        pulse(8'h11, 8'h22, 8'h33);
        u_host.frame_open();
        u_host.xfer({1'b0, ADDR_Y_DISP}, 5, d);
        u_host.frame_close();
        sel_rd(ADDR_QUALITY, 8'h33, "read after abort");
        check({7'h00, motion_n}, 8'h00, "abort kept flag");
    endtask
    task automatic t_burst();
        u_host.frame_open();
        u_host.xfer({1'b0, ADDR_STREAM}, 8, d);
        u_host.addr_gap();
        u_host.xfer(8'h00, 8, d);
        check({7'h00, d[MOTION_FLAG_BIT]}, 8'h01, "burst motion");
        u_host.xfer(8'h00, 8, d);
        check(d, 8'h11, "burst y");
        u_host.xfer(8'h00, 8, d);
        check(d, 8'h22, "burst x");
        u_host.xfer(8'h00, 8, d);
        check(d, 8'h33, "burst quality");
        u_host.xfer({1'b0, ADDR_Y_DISP}, 8, d);
        check({7'h00, miso_oe}, 8'h00, "locked after burst");
        u_host.frame_close();
        check({7'h00, motion_n}, 8'h01, "burst clears flag");
        sel_rd(ADDR_X_DISP, 8'h22, "port back after burst");
    endtask
    // full write clocked while deselected must do nothing
    task automatic t_deselect();
        pulse(8'h44, 8'h55, 8'h66);
        u_host.xfer({1'b1, ADDR_MOTION}, 8, d);
        u_host.xfer(8'h00, 8, d);
        check({6'h00, motion_n, miso_oe}, 8'h00, "ignored deselected");
        sel_rd(ADDR_Y_DISP, 8'h44, "read after select");
        sel_rd(ADDR_MOTION, 8'h80, "motion register");
    endtask
    task automatic t_power();
        int caps, stray;
        pulse(8'h00, 8'h00, 8'h00);
        check({6'h00, power_level}, 8'h00, "full rate on motion");
        repeat (85) @(negedge ref_clk);
        check({6'h00, power_level}, 8'h00, "early downshift");
        wait_level(SSM_REST1, 25);
        watch(100, caps, stray);
        check(caps[7:0], 8'h0A, "rest1 samples");
        wait_level(SSM_REST2, 200);
        watch(100, caps, stray);
        check(caps[7:0], 8'h05, "rest2 samples");
        wait_level(SSM_REST3, 300);
        watch(120, caps, stray);
        // full rest3 period: no capture may land in this window
        check(caps[7:0], 8'h00, "rest3 samples");
        check(stray[7:0], 8'h00, "led lit without capture");
        pulse(8'h00, 8'h00, 8'h00);
        check({6'h00, power_level}, 8'h00, "wake on motion");
    endtask
    initial begin
        {rst_n, motion_seen, y_delta, x_delta, quality} = '0;
        repeat (2) @(negedge ref_clk);
        t_reset();
        rst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        check({6'h00, motion_n, miso_oe}, 8'h02, "after release");
        t_read_pair();
        t_write_clear();
        t_abort();
        t_burst();
        t_deselect();
        t_power();
        tally_and_finish();
    end
    // hang guard, well past the expected run length
    initial begin
        #150000;
        mismatches++;
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
